/* File: verilog/dpio_pkg.sv */
// Purpose: constants and carrier types for the dual port I/O block
// Assumes: APB slave with 32-bit data, registers in low byte of aligned words
// Notes: printed offsets are not multiples of four, so they are register indices
package dpio_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_P1_DIR   = 16'hFFC8;
  localparam logic [15:0] IDX_P2_DIR   = 16'hFFC9;
  localparam logic [15:0] IDX_P1_DATA  = 16'hFFCA;
  localparam logic [15:0] IDX_P2_DATA  = 16'hFFCB;
  localparam logic [15:0] IDX_P1_PULL  = 16'hFFDB;
  localparam int          ADDR_W       = 18;

  // ----------------------------------------------------------------
  // reset values and field masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_P1       = 8'hF0;
  localparam logic [7:0]  RST_P2       = 8'h80;
  localparam logic [7:0]  ALL_ONES     = 8'hFF;
  localparam logic [7:0]  P1_PIN_MASK  = 8'h0F;
  localparam logic [7:0]  P2_PIN_MASK  = 8'h39;
  localparam logic [7:0]  P2_FIXED     = 8'h80;
  localparam logic [7:0]  P2_STROBES   = 8'h38;
  localparam int          STB_WR       = 5;
  localparam int          STB_RD       = 4;
  localparam int          STB_ADDR     = 3;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPIO_MODE1 = 2'b01,
    DPIO_MODE2 = 2'b10,
    DPIO_MODE3 = 2'b11
  } dpio_mode_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] drive;
    logic [7:0] oen;
  } dpio_pins_t;

  typedef struct packed {
    logic [7:0]  p1Dir;
    logic [7:0]  p2Dir;
    logic [7:0]  p1Data;
    logic [7:0]  p2Data;
    logic [7:0]  p1Pull;
    logic        modeOne;
    logic        modeValid;
    logic [31:0] prdata;
  } dpio_state_t;

endpackage

/* File: verilog/dpio_top.sv */
// Purpose: two small I/O ports with bus-function pins, APB register access
// Assumes: pins come from outside and are synchronised; strobes from the bus unit
// Notes: hardware standby acts like reset on registers; software standby blocks all writes
`timescale 1ns/1ps
module dpio_top (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       hwStandby,
  input  wire logic                       swStandby,
  input  wire logic [1:0]                 opMode,
  input  wire logic [3:0]                 addrHigh,
  input  wire logic                       writeStrobe_n,
  input  wire logic                       readStrobe_n,
  input  wire logic                       address_strobe_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [dpio_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [7:0]                 firstPortIn,
  output logic      [7:0]                 firstPortOut,
  output logic      [7:0]                 firstPortOen,
  output logic      [3:0]                 firstPortPullup,
  input  wire logic [7:0]                 secondPortIn,
  output logic      [7:0]                 secondPortOut,
  output logic      [7:0]                 secondPortOen
);
  import dpio_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic       rstLocal_n;
  logic [7:0] p1Meta;
  logic [7:0] p1Pin;
  logic [7:0] p2Meta;
  logic [7:0] p2Pin;
  logic [1:0] hsbMeta;
  logic [1:0] modeMeta;
  logic [1:0] modeSync;
  logic [1:0] modeAge;
  logic       hsbSync;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstLocal_n = rstSync[1];

  always_ff @(posedge core_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      p1Meta   <= 8'h00;
      p1Pin    <= 8'h00;
      p2Meta   <= 8'h00;
      p2Pin    <= 8'h00;
      hsbMeta  <= 2'b00;
      modeMeta <= 2'b00;
      modeSync <= 2'b00;
      modeAge  <= 2'b00;
    end else begin
      p1Meta   <= firstPortIn;
      p1Pin    <= p1Meta;
      p2Meta   <= secondPortIn;
      p2Pin    <= p2Meta;
      hsbMeta  <= {hsbMeta[0], hwStandby};
      modeMeta <= opMode;
      modeSync <= modeMeta;
      modeAge  <= {modeAge[0], 1'b1};
    end
  end
  assign hsbSync = hsbMeta[1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic [7:0] readMerge(input logic [7:0] dir, input logic [7:0] dat,
                                           input logic [7:0] pin);
    readMerge = (dir & dat) | (~dir & pin);
  endfunction

  logic        access;
  logic        setup;
  logic        wrAcc;
  logic        rdSetup;
  logic        known;
  logic        swHold;
  dpio_state_t st;
  dpio_state_t next_st;
  logic [7:0]  rd8;

  assign access  = psel & penable;
  assign setup   = psel & ~penable;
  // swHold stops software changes too: the cpu is asleep in software standby
  assign swHold  = swStandby;
  assign wrAcc   = access & pwrite & ~swHold;
  // read data is taken in the setup cycle so that it stands through the access phase
  assign rdSetup = setup & ~pwrite;
  assign known   = hit(paddr, IDX_P1_DIR) | hit(paddr, IDX_P2_DIR) | hit(paddr, IDX_P1_DATA)
                 | hit(paddr, IDX_P2_DATA) | hit(paddr, IDX_P1_PULL);
  assign pready  = 1'b1;
  assign pslverr = access & ~known;

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    rd8     = 8'h00;
    // wait until the mode synchroniser has filled, else its reset value is taken
    if (!st.modeValid && modeAge[1]) begin
      next_st.modeOne   = (dpio_mode_t'(modeSync) == DPIO_MODE1);
      next_st.modeValid = 1'b1;
    end
    if (wrAcc && hit(paddr, IDX_P1_DIR)) begin
      next_st.p1Dir = pwdata[7:0];
    end
    if (wrAcc && hit(paddr, IDX_P2_DIR)) begin
      next_st.p2Dir = pwdata[7:0];
    end
    if (wrAcc && hit(paddr, IDX_P1_DATA)) begin
      next_st.p1Data = pwdata[7:0];
    end
    if (wrAcc && hit(paddr, IDX_P2_DATA)) begin
      next_st.p2Data = pwdata[7:0] | P2_FIXED;
    end
    if (wrAcc && hit(paddr, IDX_P1_PULL)) begin
      next_st.p1Pull = (pwdata[7:0] & P1_PIN_MASK) | ~P1_PIN_MASK;
    end
    if (hit(paddr, IDX_P1_DIR) || hit(paddr, IDX_P2_DIR)) begin
      rd8 = ALL_ONES;
    end else if (hit(paddr, IDX_P1_DATA)) begin
      rd8 = (st.p1Data & ~P1_PIN_MASK)
          | (readMerge(st.p1Dir, st.p1Data, p1Pin) & P1_PIN_MASK);
    end else if (hit(paddr, IDX_P2_DATA)) begin
      rd8 = (readMerge(st.p2Dir, st.p2Data, p2Pin) & P2_PIN_MASK)
          | (readMerge(st.p2Dir, st.p2Data, ALL_ONES) & ~P2_PIN_MASK)
          | P2_FIXED;
    end else if (hit(paddr, IDX_P1_PULL)) begin
      rd8 = st.p1Pull | ~P1_PIN_MASK;
    end
    next_st.prdata = rdSetup ? {24'h000000, rd8} : st.prdata;
    if (hsbSync) begin
      next_st.p1Dir  = RST_P1;
      next_st.p1Data = RST_P1;
      next_st.p1Pull = RST_P1;
      next_st.p2Dir  = RST_P2;
      next_st.p2Data = RST_P2;
    end
  end

  always_ff @(posedge core_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      st <= '{p1Dir: RST_P1, p2Dir: RST_P2, p1Data: RST_P1, p2Data: RST_P2,
              p1Pull: RST_P1, modeOne: 1'b0, modeValid: 1'b0, prdata: 32'h00000000};
    end else begin
      st <= next_st;
    end
  end
  assign prdata = st.prdata;

  // ----------------------------------------------------------------
  // pin functions
  // ----------------------------------------------------------------
  // registers hold through software standby, so in modes 2 and 3 pins with direction 1
  // keep driving the same level without further logic
  logic [7:0] p1Src;
  logic [7:0] p2Strobes;
  logic [7:0] p2Force;

  // mode 1 carries the top address lines; direction must be set first
  assign p1Src = st.modeOne ? {4'h0, addrHigh} : (st.p1Data & P1_PIN_MASK);
  assign p2Strobes = {2'b00, writeStrobe_n, readStrobe_n, address_strobe_n, 3'b000};
  assign p2Force   = st.modeOne ? P2_STROBES : 8'h00;

  always_comb begin
    firstPortOut    = 8'h00;
    firstPortOen    = 8'hFF;
    firstPortPullup = 4'h0;
    secondPortOut   = 8'h00;
    secondPortOen   = 8'hFF;
    if (st.modeValid && !hsbSync) begin
      firstPortOut    = p1Src;
      firstPortOen    = ~(st.p1Dir & P1_PIN_MASK);
      firstPortPullup = st.p1Pull[3:0] & ~st.p1Dir[3:0];
      secondPortOut   = ((st.p2Data & ~p2Force) | (p2Strobes & p2Force)) & P2_PIN_MASK;
      secondPortOen   = ~(((st.p2Dir & P2_PIN_MASK) | p2Force));
    end
  end

endmodule // dpio_top

/* File: verif/dpio_pin_model.sv */
// Purpose: pin levels seen by the port inputs
// Assumes: low oen means the block drives the pin
// Notes: undriven pins without pull-up take the external level
`timescale 1ns/1ps
module dpio_pin_model (
  input  wire logic [7:0] drive,
  input  wire logic [7:0] oen,
  input  wire logic [7:0] pull,
  input  wire logic [7:0] ext,
  output logic      [7:0] level
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = !oen[i] ? drive[i] : (pull[i] ? 1'b1 : ext[i]);
    end
  end
endmodule // dpio_pin_model

/* File: verif/dpio_top_props.sv */
// Purpose: port checks for dpio_top
// Assumes: opMode held steady between resets
// Notes: strobe, address and software-standby pin checks wait until pins are enabled after reset
`timescale 1ns/1ps
module dpio_top_props import dpio_pkg::*; (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                hwStandby,
  input wire logic                swStandby,
  input wire logic [1:0]          opMode,
  input wire logic [3:0]          addrHigh,
  input wire logic                writeStrobe_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         prdata,
  input wire logic [7:0]          firstPortOut,
  input wire logic [7:0]          firstPortOen,
  input wire logic [3:0]          firstPortPullup,
  input wire logic [7:0]          secondPortOut,
  input wire logic [7:0]          secondPortOen
);
  // ---------------------------------
  // settle counter: sync and pin enable take several edges
  // ---------------------------------
  logic [2:0] up;
  logic       ok;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) up <= 3'h0;
    else if (hwStandby) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  assign ok = (up == 3'h7);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence rdDir;
    psel && penable && !pwrite && (paddr == {IDX_P1_DIR, 2'b00} || paddr == {IDX_P2_DIR, 2'b00});
  endsequence
  a_dir_reads_ones: assert property (rdDir |-> prdata[7:0] == 8'hFF)
    else $error("direction read not all ones");
  a_pull_needs_input: assert property ((firstPortPullup & ~firstPortOen[3:0]) == 4'h0)
    else $error("pull-up on a driven pin");
  a_hw_pull_off: assert property (hwStandby [*3] |-> firstPortPullup == 4'h0)
    else $error("pull-up on in hardware standby");
  a_p1_upper_idle: assert property (firstPortOen[7:4] == 4'hF)
    else $error("first port upper bit driven");
  a_p2_reserved_idle: assert property (secondPortOen[7:6] == 2'b11 && secondPortOen[2:1] == 2'b11)
    else $error("second port reserved bit driven");
  a_strobes_driven: assert property (ok && opMode == 2'b01 |->
    secondPortOen[5:3] == 3'b000 && secondPortOut[5] == writeStrobe_n) else $error("strobe pins not driven");
  a_addr_output: assert property (ok && opMode == 2'b01 |->
    ((firstPortOut[3:0] ^ addrHigh) & ~firstPortOen[3:0]) == 4'h0) else $error("address pin value wrong");
  a_swstby_hold: assert property (ok && swStandby && $past(swStandby) && !hwStandby |->
    $stable(firstPortOen) && $stable(secondPortOen)) else $error("direction changed in software standby");
endmodule // dpio_top_props
bind dpio_top dpio_top_props u_props (.core_clk, .rst_n, .hwStandby, .swStandby, .opMode, .addrHigh,
  .writeStrobe_n, .psel, .penable, .pwrite, .paddr, .prdata, .firstPortOut, .firstPortOen,
  .firstPortPullup, .secondPortOut, .secondPortOen);

/* File: verif/test_dual_port_io_with_bus_pins.sv */
// Purpose: register and pin tests for dpio_top
// Assumes: APB master, read data taken at the edge where pready is seen high
// Notes: each operating mode is entered through its own reset
`timescale 1ns/1ps
module test_dual_port_io_with_bus_pins;
  import dpio_pkg::*;
  logic              core_clk = 0, rst_n = 0, hwStandby = 0, swStandby = 0, wrS = 1;
  logic              rdS = 1, asS = 1, err;
  logic              psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [1:0]        opMode = 2'b01;
  logic [3:0]        addrHigh = 4'hA, p1Pull;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata;
  logic [7:0]        p1In, p1Out, p1Oen, p2In, p2Out, p2Oen, v;
  int                fail_count = 0, comparisons = 0;
  always #2 core_clk = ~core_clk;
  dpio_top dut (.core_clk, .rst_n, .hwStandby, .swStandby, .opMode, .addrHigh, .writeStrobe_n(wrS),
    .readStrobe_n(rdS), .address_strobe_n(asS), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .firstPortIn(p1In), .firstPortOut(p1Out), .firstPortOen(p1Oen),
    .firstPortPullup(p1Pull), .secondPortIn(p2In), .secondPortOut(p2Out), .secondPortOen(p2Oen));
  dpio_pin_model m1 (.drive(p1Out), .oen(p1Oen), .pull({4'h0, p1Pull}), .ext(8'h05), .level(p1In));
  dpio_pin_model m2 (.drive(p2Out), .oen(p2Oen), .pull(8'h00), .ext(8'h00), .level(p2In));
  // ---------------------------------
  // tasks
  // ---------------------------------
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    v   = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test;
    end
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(v, exp);
  endtask
  task automatic rst(input logic [1:0] m);
    rst_n <= 0; opMode <= m;
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    repeat (6) @(posedge core_clk);
  endtask
  // ---------------------------------
  // sequence
  // ---------------------------------
  initial begin
    rst(2'b01);
    rdchk(IDX_P1_DIR, 8'hFF);
    chk({7'h00, err}, 8'h00);
    rdchk(IDX_P2_DIR, 8'hFF);
    rdchk(IDX_P1_DATA, 8'hF5);
    rdchk(IDX_P1_PULL, 8'hF0);
    rdchk(IDX_P2_DATA, 8'hFE);
    bus(IDX_P1_PULL, 1'b1, 8'h0F);
    chk({4'h0, p1Pull}, 8'h0F);
    rdchk(IDX_P1_PULL, 8'hFF);
    bus(IDX_P1_DIR, 1'b1, 8'hF3);
    chk({p1Oen[3:0], p1Pull}, 8'hCC);
    chk({6'h0, p1Out[1:0]}, 8'h02);
    bus(IDX_P1_DATA, 1'b1, 8'h5A);
    rdchk(IDX_P1_DATA, 8'h5E);
    wrS <= 1'b0;
    asS <= 1'b0;
    bus(IDX_P2_DIR, 1'b1, 8'h01);
    bus(IDX_P2_DATA, 1'b1, 8'h00);
    chk({p2Oen[5:3], p2Oen[0], p2Out[0]}, 8'h00);
    chk({5'h00, p2Out[5:3]}, 8'h02);
    rdchk(IDX_P2_DATA, 8'hD6);
    swStandby <= 1;
    bus(IDX_P1_DIR, 1'b1, 8'h00);
    chk({4'h0, p1Oen[3:0]}, 8'h0C);
    swStandby <= 0; hwStandby <= 1;
    repeat (4) @(posedge core_clk);
    chk({4'h0, p1Pull}, 8'h00);
    hwStandby <= 0;
    repeat (6) @(posedge core_clk);
    rdchk(IDX_P1_DATA, 8'hF5);
    chk({4'h0, p1Oen[3:0]}, 8'h0F);
    rdchk(16'hFFCC, 8'h00);
    chk({7'h00, err}, 8'h01);
    for (int m = 2; m < 4; m++) begin
      rst(m[1:0]);
      bus(IDX_P2_DIR, 1'b1, 8'h46);
      bus(IDX_P2_DATA, 1'b1, 8'h7F);
      rdchk(IDX_P2_DATA, 8'hC6);
      chk(p2Oen, 8'hFF);
      bus(IDX_P1_DIR, 1'b1, 8'h0F);
      bus(IDX_P1_DATA, 1'b1, 8'h09);
      chk({p1Oen[3:0], p1Out[3:0]}, 8'h09);
    end
    finish_test;
  end
endmodule // test_dual_port_io_with_bus_pins
